//--- core/ett_pkg.sv
package ett_pkg;
	localparam int AW = 24;
	localparam int DW = 16;
	localparam int SW = 4;
	localparam int XW = 8;
	localparam int EVW = 16;
	localparam int SELW = 5;
	localparam int NSEG = 4;
	localparam int NBP = 3;
	localparam int NTERM = 4;
	localparam int BLKW = 6;
	localparam int REGW = 7;
	localparam int CNTW = 12;
	localparam int TMRW = 24;
	localparam int TRACE_DEPTH = 255;
	localparam int TPW = 8;
	localparam int ENTW = 64;
	localparam int SEQW = 16;
	localparam int MAP_LIMIT_KB = 30;
	localparam int BLOCK_KB = 2;
	localparam int MAP_MAX_BLOCKS = MAP_LIMIT_KB / BLOCK_KB;
	// Register word indices
	localparam logic [5:0] R_CTRL = 6'h00;
	localparam logic [5:0] R_STATUS = 6'h01;
	localparam logic [5:0] R_SEL = 6'h02;
	localparam logic [5:0] R_TDELAY = 6'h03;
	localparam logic [5:0] R_CNT_CFG = 6'h04;
	localparam logic [5:0] R_CNT_VAL = 6'h05;
	localparam logic [5:0] R_TMR_CFG = 6'h06;
	localparam logic [5:0] R_TMR_VAL = 6'h07;
	localparam logic [5:0] R_TERM0 = 6'h08;
	localparam logic [5:0] R_RANGE_LO = 6'h0c;
	localparam logic [5:0] R_RANGE_HI = 6'h0d;
	localparam logic [5:0] R_RANGE_CTL = 6'h0e;
	localparam logic [5:0] R_TIDX = 6'h0f;
	localparam logic [5:0] R_TDATA_LO = 6'h10;
	localparam logic [5:0] R_TDATA_HI = 6'h11;
	localparam logic [5:0] R_SEG0 = 6'h14;
	localparam logic [5:0] R_BP0 = 6'h28;
	localparam int SEG_STRIDE = 4;
	localparam int BP_STRIDE = 8;
	// Simple event positions and selector codes
	localparam int EV_BP0 = 0;
	localparam int EV_RANGE = 3;
	localparam int EV_LAT0 = 4;
	localparam int EV_CD = 7;
	localparam int EV_IS0 = 8;
	localparam int EV_IS1 = 9;
	localparam int EV_IM = 10;
	localparam int EV_TD = 11;
	localparam logic [SELW-1:0] SEL_X0 = 5'h10;
	localparam logic [SELW-1:0] SEL_X1 = 5'h11;
	localparam logic [1:0] SRC_EVENT = 2'h0;
	localparam logic [1:0] SRC_INSN = 2'h1;
	localparam logic [1:0] SRC_MEM = 2'h2;
	localparam logic [1:0] SRC_CLK = 2'h3;
	typedef enum logic [1:0] {
		TR_IDLE = 2'b00, TR_RUN = 2'b01, TR_DELAY = 2'b10, TR_DONE = 2'b11
	} ett_trace_state_type;
	typedef struct packed {
		logic stb; logic wr; logic [AW-1:0] vaddr; logic [AW-1:0] paddr;
		logic [DW-1:0] data; logic [SW-1:0] status; logic [XW-1:0] ext;
		logic pod_sync_input_0; logic pod_sync_input_1;
		logic instruction_start_pin; logic nonseq; logic user_mode_pin;
		logic upper_byte_enable_n; logic data_in_direction_n;
	} ett_pins_type;
	typedef struct packed {
		logic [11:0] rsv; logic [BLKW-1:0] last; logic [BLKW-1:0] first;
		logic [REGW-1:0] region; logic en;
	} ett_seg_type;
	typedef struct packed {
		logic [19:0] rsv; logic [3:0] pmask; logic din_n; logic ube_n;
		logic user; logic wr; logic no_halt_option; logic virt;
		logic mem_mode; logic en;
	} ett_bp_ctrl_type;
	typedef struct packed {
		logic [11:0] rsv; logic [SW-1:0] status; logic [DW-1:0] data;
	} ett_bp_data_type;
	typedef struct packed {
		logic [9:0] rsv; logic qual_en; logic stop_en; logic [SELW-1:0] term;
		logic [SELW-1:0] qual; logic [SELW-1:0] trig; logic [SELW-1:0] stop;
	} ett_sel_type;
	typedef struct packed {
		logic [8:0] rsv; logic [SELW-1:0] ev; logic [1:0] src;
		logic [3:0] rsv2; logic [CNTW-1:0] preset;
	} ett_cnt_cfg_type;
	typedef struct packed {
		logic [14:0] rsv; logic [SELW-1:0] stop; logic [SELW-1:0] start;
		logic [SELW-1:0] ev; logic [1:0] src;
	} ett_tmr_cfg_type;
	typedef struct packed {
		logic [29:0] rsv; logic bus_mode; logic en;
	} ett_ctrl_type;
	typedef struct packed {
		logic [28:0] rsv; logic virt; logic no_halt_option; logic en;
	} ett_range_type;
	typedef struct packed {
		logic [EVW-1:0] inv; logic [EVW-1:0] sel;
	} ett_term_type;
endpackage

//--- core/ett_event_trace.sv
`timescale 1ns/10ps
// Operation
// - At most four separate segments are redirected to emulation memory.
// - Each segment lies inside one aligned 128K byte region.
// - Segments start and end on aligned 2K block boundaries.
// - All segments together may cover at most 30K bytes.
// - Accesses in a mapped segment go to emulation memory only.
// - Every 2K block has write protect; protected write raises illegal-map event.
// - Protected writes are blocked in emulation memory, only detected in target.
// - Execution breakpoint fires just before executing instruction from its address.
// - Memory breakpoint compares masked address, data, status, pins; virtual or physical.
// - Range breakpoint fires on any access inside lower to upper range.
// - Breakpoints halt at once unless no-halt option set.
// - Each breakpoint except the range breakpoint has a latched event, set after firing, held until cleared.
// - 12-bit counter counts selected source, raises count-reached event.
// - Events combine through NOT, AND, OR into expressions.
// - Emulation halts when selected event or expression becomes true.
// - 255-entry trace buffer, program flow or memory bus mode.
// - Flow entry holds non-sequential PC and sequential instruction count.
// - Bus entry holds address, data, status, pod inputs and four pins.
// - In bus mode a qualifying event selects which cycles are stored.
// - Tracing stops a further 1 to 255 entries after terminating event.
// - 24-bit timer with overflow, selectable source, start and stop events.
// - One trigger follows a chosen event, other pulses per trace write.
module ett_event_trace (
	input  wire logic                 CLK,
	input  wire logic                 SRST,
	input  wire logic [5:0]           REG_ADDR,
	input  wire logic [31:0]          REG_WDATA,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_RD,
	output logic [31:0]               REG_RDATA,
	input  wire ett_pkg::ett_pins_type BUS_PINS,
	output logic                      EMU_SEL,
	output logic                      EMU_WE,
	output logic                      TARGET_EN,
	output logic                      HALT_REQ,
	output logic                      GENERAL_TRIGGER_OUT,
	output logic                      TRACE_TRIGGER_OUT
);
	import ett_pkg::*;

	// Configuration state
	ett_ctrl_type      ctrl;
	ett_sel_type       sel;
	ett_cnt_cfg_type   cnt_cfg;
	ett_tmr_cfg_type   tmr_cfg;
	ett_range_type     range_ctl;
	logic [AW-1:0]     range_lo;
	logic [AW-1:0]     range_hi;
	logic [TPW-1:0]    trace_delay;
	logic [TPW-1:0]    trace_idx;
	ett_seg_type       seg_cfg [NSEG];
	logic [63:0]       seg_wp [NSEG];
	ett_bp_ctrl_type   bp_ctl [NBP];
	logic [AW-1:0]     bp_addr [NBP];
	logic [AW-1:0]     bp_amask [NBP];
	ett_bp_data_type   bp_dm [NBP];
	ett_bp_data_type   bp_dk [NBP];
	ett_term_type      terms [NTERM];
	// Runtime state
	ett_pins_type      pin_meta;
	ett_pins_type      pins;
	logic              stb_prev;
	logic [NBP-1:0]    latched;
	logic              halted;
	logic              illegal_seen;
	logic [CNTW-1:0]   cnt_val;
	logic              count_reached_event;
	logic [TMRW-1:0]   tmr_val;
	logic              tmr_ovf;
	logic              tmr_run;
	ett_trace_state_type tr_state;
	logic [TPW-1:0]    wptr;
	logic [TPW-1:0]    dcount;
	logic [SEQW-1:0]   seq_cnt;
	logic [ENTW-1:0]   trace_mem [TRACE_DEPTH];
	// Combinational results
	logic              cyc;
	logic              map_hit;
	logic              map_prot;
	logic              map_ok;
	logic [EVW-1:0]    ev;
	logic [NBP-1:0]    bp_fire;
	logic              range_fire;
	logic              expr0;
	logic              expr1;
	logic              bp_halt;
	logic              trace_wr;
	logic [ENTW-1:0]   trace_entry;
	logic              term_hit;
	logic              wr_status;

	// Segment contains address in its region and block span
	function automatic logic seg_has(ett_seg_type s, logic [AW-1:0] a);
		logic [BLKW-1:0] blk;
		blk = a[AW-REGW-1 -: BLKW];
		seg_has = s.en && a[AW-1 -: REGW] == s.region &&
			blk >= s.first && blk <= s.last;
	endfunction

	// Breakpoint comparison, execution or memory reference
	function automatic logic bp_hit(ett_bp_ctrl_type c, logic [AW-1:0] a,
			logic [AW-1:0] am, ett_bp_data_type dm, ett_bp_data_type dk,
			ett_pins_type p);
		logic [AW-1:0] ad;
		logic [3:0] pv;
		ad = c.virt ? p.vaddr : p.paddr;
		pv = {p.data_in_direction_n, p.upper_byte_enable_n, p.user_mode_pin, p.wr};
		bp_hit = c.en && ((ad ^ a) & ~am) == '0 && (c.mem_mode ?
			((({p.status, p.data} ^ {dm.status, dm.data}) &
			~{dk.status, dk.data}) == '0 &&
			((pv ^ {c.din_n, c.ube_n, c.user, c.wr}) & ~c.pmask) == '0) :
			p.instruction_start_pin);
	endfunction

	// Product term: all selected events match their polarity
	function automatic logic term_true(ett_term_type t, logic [EVW-1:0] e);
		term_true = t.sel != '0 && ((e ^ t.inv) & t.sel) == t.sel;
	endfunction

	// Pick a simple event or one of the two expressions
	function automatic logic pick(logic [SELW-1:0] code, logic [EVW-1:0] e,
			logic x0, logic x1);
		if (code == SEL_X0)
			pick = x0;
		else if (code == SEL_X1)
			pick = x1;
		else if (code < SEL_X0)
			pick = e[code[3:0]];
		else
			pick = 1'b0;
	endfunction

	// Counting source for counter and timer
	function automatic logic src_tick(logic [1:0] src, logic c, logic insn,
			logic e);
		case (src)
			SRC_EVENT: src_tick = c & e;
			SRC_INSN: src_tick = c & insn;
			SRC_MEM: src_tick = c;
			SRC_CLK: src_tick = 1'b1;
			default: src_tick = 1'b0;
		endcase
	endfunction

	// Bus pins cross from the target domain through two flops
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pin_meta <= '0;
			pins <= '0;
			stb_prev <= 1'b0;
		end else begin
			pin_meta <= BUS_PINS;
			pins <= pin_meta;
			stb_prev <= pins.stb;
		end
	end

	// One evaluation slot per bus cycle, at strobe rise
	assign cyc = pins.stb & ~stb_prev;

	// Mapping: first matching segment wins, limits checked as a whole
	always_comb begin
		int unsigned blocks;
		blocks = 0;
		map_hit = 1'b0;
		map_prot = 1'b0;
		for (int i = 0; i < NSEG; i++) begin
			if (seg_cfg[i].en && seg_cfg[i].last >= seg_cfg[i].first)
				blocks += 32'(seg_cfg[i].last - seg_cfg[i].first) + 1;
			if (seg_has(seg_cfg[i], pins.paddr) && !map_hit) begin
				map_hit = 1'b1;
				map_prot = seg_wp[i][pins.paddr[AW-REGW-1 -: BLKW]];
			end
		end
		map_ok = blocks <= MAP_MAX_BLOCKS;
	end

	// Emulation memory steering, latched per bus cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			EMU_SEL <= 1'b0;
			EMU_WE <= 1'b0;
			TARGET_EN <= 1'b1;
		end else if (cyc) begin
			EMU_SEL <= map_hit & map_ok;
			EMU_WE <= map_hit & map_ok & pins.wr & ~map_prot;
			TARGET_EN <= ~(map_hit & map_ok);
		end
	end

	// Simple events and expressions
	always_comb begin
		for (int i = 0; i < NBP; i++)
			bp_fire[i] = cyc & bp_hit(bp_ctl[i], bp_addr[i], bp_amask[i],
				bp_dm[i], bp_dk[i], pins);
		range_fire = cyc & range_ctl.en &
			((range_ctl.virt ? pins.vaddr : pins.paddr) >= range_lo) &
			((range_ctl.virt ? pins.vaddr : pins.paddr) <= range_hi);
		ev = '0;
		ev[EV_BP0 +: NBP] = bp_fire;
		ev[EV_RANGE] = range_fire;
		ev[EV_LAT0 +: NBP] = latched;
		ev[EV_CD] = count_reached_event;
		ev[EV_IS0] = pins.pod_sync_input_0;
		ev[EV_IS1] = pins.pod_sync_input_1;
		ev[EV_IM] = cyc & pins.wr & map_hit & map_prot;
		ev[EV_TD] = tr_state == TR_DONE;
		expr0 = cyc & (term_true(terms[0], ev) | term_true(terms[1], ev));
		expr1 = cyc & (term_true(terms[2], ev) | term_true(terms[3], ev));
		bp_halt = range_fire & ~range_ctl.no_halt_option;
		for (int i = 0; i < NBP; i++)
			bp_halt |= bp_fire[i] & ~bp_ctl[i].no_halt_option;
	end

	assign wr_status = REG_WR && REG_ADDR == R_STATUS;

	// Sticky flags: hardware set wins over a software clear
	always_ff @(posedge CLK) begin
		if (SRST) begin
			latched <= '0;
			halted <= 1'b0;
			illegal_seen <= 1'b0;
		end else begin
			if (wr_status)
				latched <= latched & ~REG_WDATA[NBP-1:0];
			if (wr_status && REG_WDATA[NBP])
				halted <= 1'b0;
			if (wr_status && REG_WDATA[NBP+1])
				illegal_seen <= 1'b0;
			for (int i = 0; i < NBP; i++)
				if (bp_fire[i])
					latched[i] <= 1'b1;
			if (bp_halt)
				halted <= 1'b1;
			if (cyc && sel.stop_en && pick(sel.stop, ev, expr0, expr1))
				halted <= 1'b1;
			if (ev[EV_IM])
				illegal_seen <= 1'b1;
		end
	end

	// Count-down event counter
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cnt_val <= '0;
			count_reached_event <= 1'b0;
		end else if (REG_WR && REG_ADDR == R_CNT_CFG) begin
			cnt_val <= REG_WDATA[CNTW-1:0];
			count_reached_event <= 1'b0;
		end else if (!count_reached_event && src_tick(cnt_cfg.src, cyc,
				pins.instruction_start_pin,
				pick(cnt_cfg.ev, ev, expr0, expr1))) begin
			if (cnt_val <= CNTW'(1)) begin
				cnt_val <= '0;
				count_reached_event <= 1'b1;
			end else
				cnt_val <= cnt_val - CNTW'(1);
		end
	end

	// Execution timer: stop beats start in the same cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			tmr_val <= '0;
			tmr_ovf <= 1'b0;
			tmr_run <= 1'b0;
		end else if (REG_WR && REG_ADDR == R_TMR_CFG) begin
			tmr_val <= '0;
			tmr_ovf <= 1'b0;
			tmr_run <= 1'b0;
		end else begin
			if (cyc && pick(tmr_cfg.stop, ev, expr0, expr1))
				tmr_run <= 1'b0;
			else if (cyc && pick(tmr_cfg.start, ev, expr0, expr1))
				tmr_run <= 1'b1;
			if (tmr_run && src_tick(tmr_cfg.src, cyc,
					pins.instruction_start_pin,
					pick(tmr_cfg.ev, ev, expr0, expr1))) begin
				tmr_val <= tmr_val + TMRW'(1);
				if (&tmr_val)
					tmr_ovf <= 1'b1;
			end
		end
	end

	// Trace capture decision and entry layout
	always_comb begin
		term_hit = cyc & pick(sel.term, ev, expr0, expr1);
		trace_wr = 1'b0;
		trace_entry = '0;
		if (tr_state == TR_RUN || tr_state == TR_DELAY) begin
			if (ctrl.bus_mode) begin
				trace_wr = cyc & (~sel.qual_en | pick(sel.qual, ev, expr0, expr1));
				trace_entry = ENTW'({pins.data_in_direction_n,
					pins.upper_byte_enable_n, pins.user_mode_pin,
					pins.instruction_start_pin, pins.ext, pins.status,
					pins.data, pins.paddr});
			end else begin
				trace_wr = cyc & pins.instruction_start_pin & pins.nonseq;
				trace_entry = ENTW'({seq_cnt, pins.paddr});
			end
		end
	end

	// Trace sequencer with delayed termination
	always_ff @(posedge CLK) begin
		if (SRST) begin
			tr_state <= TR_IDLE;
			wptr <= '0;
			dcount <= '0;
			seq_cnt <= '0;
		end else if (REG_WR && REG_ADDR == R_CTRL) begin
			tr_state <= REG_WDATA[0] ? TR_RUN : TR_IDLE;
			wptr <= '0;
			seq_cnt <= '0;
		end else begin
			if (trace_wr)
				wptr <= (wptr == TPW'(TRACE_DEPTH - 1)) ? '0 : wptr + TPW'(1);
			if (cyc && pins.instruction_start_pin && !ctrl.bus_mode)
				seq_cnt <= trace_wr ? '0 : seq_cnt + SEQW'(1);
			case (tr_state)
				TR_RUN: begin
					if (term_hit) begin
						tr_state <= TR_DELAY;
						dcount <= (trace_delay == '0) ? TPW'(1) : trace_delay;
					end
				end
				TR_DELAY: begin
					if (trace_wr) begin
						dcount <= dcount - TPW'(1);
						if (dcount == TPW'(1))
							tr_state <= TR_DONE;
					end
				end
				TR_IDLE, TR_DONE: begin
					dcount <= '0;
				end
				default: tr_state <= TR_IDLE;
			endcase
		end
	end

	// Trace storage; contents are not cleared by reset
	always_ff @(posedge CLK) begin
		if (trace_wr)
			trace_mem[wptr] <= trace_entry;
	end

	// External triggers and halt request
	always_ff @(posedge CLK) begin
		if (SRST) begin
			GENERAL_TRIGGER_OUT <= 1'b0;
			TRACE_TRIGGER_OUT <= 1'b0;
			HALT_REQ <= 1'b0;
		end else begin
			if (cyc)
				GENERAL_TRIGGER_OUT <= pick(sel.trig, ev, expr0, expr1);
			TRACE_TRIGGER_OUT <= trace_wr;
			HALT_REQ <= halted | bp_halt;
		end
	end

	// Register writes from the monitor
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl <= '0;
			sel <= '0;
			cnt_cfg <= '0;
			tmr_cfg <= '0;
			range_ctl <= '0;
			range_lo <= '0;
			range_hi <= '0;
			trace_delay <= TPW'(1);
			trace_idx <= '0;
			for (int i = 0; i < NSEG; i++) begin
				seg_cfg[i] <= '0;
				seg_wp[i] <= '0;
			end
			for (int i = 0; i < NBP; i++) begin
				bp_ctl[i] <= '0;
				bp_addr[i] <= '0;
				bp_amask[i] <= '0;
				bp_dm[i] <= '0;
				bp_dk[i] <= '0;
			end
			for (int i = 0; i < NTERM; i++)
				terms[i] <= '0;
		end else if (REG_WR) begin
			case (REG_ADDR)
				R_CTRL: ctrl <= REG_WDATA;
				R_SEL: sel <= REG_WDATA;
				R_TDELAY: trace_delay <= REG_WDATA[TPW-1:0];
				R_CNT_CFG: cnt_cfg <= REG_WDATA;
				R_TMR_CFG: tmr_cfg <= REG_WDATA;
				R_RANGE_LO: range_lo <= REG_WDATA[AW-1:0];
				R_RANGE_HI: range_hi <= REG_WDATA[AW-1:0];
				R_RANGE_CTL: range_ctl <= REG_WDATA;
				R_TIDX: trace_idx <= REG_WDATA[TPW-1:0];
				default: ;
			endcase
			for (int i = 0; i < NTERM; i++)
				if (REG_ADDR == R_TERM0 + 6'(i))
					terms[i] <= REG_WDATA;
			for (int i = 0; i < NSEG; i++) begin
				if (REG_ADDR == R_SEG0 + 6'(SEG_STRIDE * i))
					seg_cfg[i] <= REG_WDATA;
				if (REG_ADDR == R_SEG0 + 6'(SEG_STRIDE * i + 1))
					seg_wp[i][31:0] <= REG_WDATA;
				if (REG_ADDR == R_SEG0 + 6'(SEG_STRIDE * i + 2))
					seg_wp[i][63:32] <= REG_WDATA;
			end
			for (int i = 0; i < NBP; i++) begin
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i))
					bp_addr[i] <= REG_WDATA[AW-1:0];
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 1))
					bp_amask[i] <= REG_WDATA[AW-1:0];
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 2))
					bp_dm[i] <= REG_WDATA;
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 3))
					bp_dk[i] <= REG_WDATA;
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 4))
					bp_ctl[i] <= REG_WDATA;
			end
		end
	end

	// Register reads, data valid in the following cycle only
	always_ff @(posedge CLK) begin
		if (SRST || !REG_RD)
			REG_RDATA <= '0;
		else begin
			REG_RDATA <= '0;
			case (REG_ADDR)
				R_CTRL: REG_RDATA <= ctrl;
				R_STATUS: REG_RDATA <= {8'h00, wptr, 7'h00, !map_ok,
					tmr_ovf, tr_state == TR_DONE, count_reached_event,
					illegal_seen, halted, latched};
				R_SEL: REG_RDATA <= sel;
				R_TDELAY: REG_RDATA <= 32'(trace_delay);
				R_CNT_CFG: REG_RDATA <= cnt_cfg;
				R_CNT_VAL: REG_RDATA <= 32'(cnt_val);
				R_TMR_CFG: REG_RDATA <= tmr_cfg;
				R_TMR_VAL: REG_RDATA <= {7'h00, tmr_ovf, tmr_val};
				R_RANGE_LO: REG_RDATA <= 32'(range_lo);
				R_RANGE_HI: REG_RDATA <= 32'(range_hi);
				R_RANGE_CTL: REG_RDATA <= range_ctl;
				R_TIDX: REG_RDATA <= 32'(trace_idx);
				R_TDATA_LO: REG_RDATA <= trace_mem[trace_idx][31:0];
				R_TDATA_HI: REG_RDATA <= trace_mem[trace_idx][63:32];
				default: ;
			endcase
			for (int i = 0; i < NTERM; i++)
				if (REG_ADDR == R_TERM0 + 6'(i))
					REG_RDATA <= terms[i];
			for (int i = 0; i < NSEG; i++) begin
				if (REG_ADDR == R_SEG0 + 6'(SEG_STRIDE * i))
					REG_RDATA <= seg_cfg[i];
				if (REG_ADDR == R_SEG0 + 6'(SEG_STRIDE * i + 1))
					REG_RDATA <= seg_wp[i][31:0];
				if (REG_ADDR == R_SEG0 + 6'(SEG_STRIDE * i + 2))
					REG_RDATA <= seg_wp[i][63:32];
			end
			for (int i = 0; i < NBP; i++) begin
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i))
					REG_RDATA <= 32'(bp_addr[i]);
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 1))
					REG_RDATA <= 32'(bp_amask[i]);
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 2))
					REG_RDATA <= bp_dm[i];
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 3))
					REG_RDATA <= bp_dk[i];
				if (REG_ADDR == R_BP0 + 6'(BP_STRIDE * i + 4))
					REG_RDATA <= bp_ctl[i];
			end
		end
	end
endmodule

//--- sim/ett_cpu_model.sv
`timescale 1ns/10ps
module ett_cpu_model (
	input  wire logic             clk,
	output ett_pkg::ett_pins_type pins
);
	import ett_pkg::*;
	initial pins = '0;
	// Pins held through the whole cycle; data inverted once the cycle is over
	task automatic cyc(input logic [23:0] a, input logic w, input logic [15:0] dt,
		input logic s, input logic p0, input logic p1);
		@(posedge clk);
		pins.stb <= 1'b1;
		pins.wr <= w;
		pins.vaddr <= a;
		pins.paddr <= a;
		pins.data <= dt;
		pins.ext <= 8'($urandom);
		pins.instruction_start_pin <= s;
		pins.nonseq <= s;
		pins.pod_sync_input_0 <= p0;
		pins.pod_sync_input_1 <= p1;
		pins.data_in_direction_n <= w;
		repeat (3) @(posedge clk);
		pins.stb <= 1'b0;
		repeat (3) @(posedge clk);
		pins.data <= ~dt;
	endtask
endmodule

//--- sim/ett_event_trace_assertions.sv
`timescale 1ns/10ps
module ett_event_trace_assertions (
	input wire logic                  CLK,
	input wire logic                  SRST,
	input wire logic [5:0]            REG_ADDR,
	input wire logic [31:0]           REG_WDATA,
	input wire logic                  REG_WR,
	input wire logic                  REG_RD,
	input wire logic [31:0]           REG_RDATA,
	input wire ett_pkg::ett_pins_type BUS_PINS,
	input wire logic                  EMU_SEL,
	input wire logic                  EMU_WE,
	input wire logic                  TARGET_EN,
	input wire logic                  HALT_REQ,
	input wire logic                  GENERAL_TRIGGER_OUT,
	input wire logic                  TRACE_TRIGGER_OUT
);
	import ett_pkg::*;
	logic [4:0] start_hist;
	logic       last_wr;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// Recent cycle starts; outputs may only move in their wake
	always_ff @(posedge CLK) begin
		if (SRST)
			start_hist <= 5'h0;
		else
			start_hist <= {start_hist[3:0], $rose(BUS_PINS.stb)};
	end
	// Direction of the latest bus cycle
	always_ff @(posedge CLK) begin
		if ($rose(BUS_PINS.stb))
			last_wr <= BUS_PINS.wr;
	end
	sequence halt_clear_s;
		REG_WR && REG_ADDR == R_STATUS && REG_WDATA[3] && start_hist == 5'h0;
	endsequence
	sequence out_move_s;
		$changed(EMU_SEL) || $changed(GENERAL_TRIGGER_OUT) || $rose(HALT_REQ)
			|| $rose(TRACE_TRIGGER_OUT);
	endsequence
	target_excl_a: assert property (TARGET_EN == !EMU_SEL)
		else $error("target and emulation both chosen");
	emu_write_a: assert property (EMU_WE |-> EMU_SEL)
		else $error("emulation write outside map");
	write_cause_a: assert property ($rose(EMU_WE) |-> last_wr)
		else $error("emulation write on a read");
	trace_pulse_a: assert property (TRACE_TRIGGER_OUT |=> !TRACE_TRIGGER_OUT [*3])
		else $error("trace trigger too long");
	halt_hold_a: assert property (HALT_REQ && !REG_WR && !$past(REG_WR) |=> HALT_REQ)
		else $error("halt dropped");
	halt_clear_a: assert property (halt_clear_s |-> ##2 !HALT_REQ)
		else $error("halt not cleared");
	halt_status_a: assert property (REG_RD && REG_ADDR == R_STATUS |=>
		REG_RDATA[3] == $past(HALT_REQ))
		else $error("halt status mismatch");
	bus_align_a: assert property (out_move_s |-> start_hist != 5'h0)
		else $error("output moved off cycle");
endmodule
bind ett_event_trace ett_event_trace_assertions u_chk (.CLK(CLK), .SRST(SRST),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .BUS_PINS(BUS_PINS), .EMU_SEL(EMU_SEL), .EMU_WE(EMU_WE),
	.TARGET_EN(TARGET_EN), .HALT_REQ(HALT_REQ),
	.GENERAL_TRIGGER_OUT(GENERAL_TRIGGER_OUT), .TRACE_TRIGGER_OUT(TRACE_TRIGGER_OUT));

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench;
	import ett_pkg::*;
	logic         clk, srst, wr, rd, emu_sel, emu_we, tgt_en, halt, gtrig, ttrig;
	logic [5:0]   addr;
	logic [31:0]  wdata, rdata, v;
	ett_pins_type pins;
	int           n_errors, checked, n_trc, b, d;
	logic [6:0]   rg;
	logic [10:0]  o;
	logic [23:0]  a, lo;
	logic [15:0]  td;
	ett_event_trace dut (.CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .BUS_PINS(pins), .EMU_SEL(emu_sel),
		.EMU_WE(emu_we), .TARGET_EN(tgt_en), .HALT_REQ(halt),
		.GENERAL_TRIGGER_OUT(gtrig), .TRACE_TRIGGER_OUT(ttrig));
	ett_cpu_model cpu (.clk(clk), .pins(pins));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Each trace entry shows as one single-clock pulse
	always @(posedge clk) if (ttrig === 1'b1) n_trc++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic chb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	// Trailing delay lets the write land before anything is looked at
	task automatic wreg(input logic [5:0] ad, input logic [31:0] q);
		@(posedge clk);
		addr <= ad;
		wdata <= q;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [5:0] ad, output logic [31:0] q);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	function automatic logic [31:0] seg(input logic [6:0] r, input int f, input int l);
		return {12'h0, l[5:0], f[5:0], r, 1'b1};
	endfunction
	function automatic logic [23:0] blk(input logic [6:0] r, input int bn, input logic [10:0] of);
		return {r, bn[5:0], of};
	endfunction
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		summarize();
	end
	initial begin
		srst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 6'h0;
		wdata = 32'h0;
		void'($urandom(11615));
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		#1 chb(tgt_en, 1'b1);
		rreg(R_TDELAY, v);
		chk(v, 32'h1);
		rreg(6'h3f, v);
		chk(v, 32'h0);
		// Segment of blocks 2..3; edges of the segment first, then random
		rg = 7'($urandom);
		wreg(R_SEG0, seg(rg, 2, 3));
		for (int i = 0; i < 12; i++) begin
			b = (i < 4) ? i + 1 : int'($urandom % 6);
			o = (i < 4) ? (i[0] ? 11'h0 : 11'h7ff) : 11'($urandom);
			cpu.cyc(blk(rg, b, o), 1'b0, 16'($urandom), 1'b0, 1'b0, 1'b0);
			chb(emu_sel, b inside {2, 3});
		end
		cpu.cyc(blk(~rg, 2, 11'h0), 1'b0, 16'h0, 1'b0, 1'b0, 1'b0);
		chb(emu_sel, 1'b0);
		// Protect block 3 only
		wreg(R_SEG0 + 6'h1, 32'h8);
		cpu.cyc(blk(rg, 2, 11'h0), 1'b1, 16'h1, 1'b0, 1'b0, 1'b0);
		chb(emu_we, 1'b1);
		cpu.cyc(blk(rg, 3, 11'h10), 1'b1, 16'h2, 1'b0, 1'b0, 1'b0);
		chb(emu_sel, 1'b1);
		chb(emu_we, 1'b0);
		rreg(R_STATUS, v);
		chb(v[4], 1'b1);
		// 15 blocks mapped is the most; 16 drops redirection
		for (int l = 12; l < 14; l++) begin
			wreg(R_SEG0 + 6'h4, seg(~rg, 0, l));
			cpu.cyc(blk(rg, 2, 11'h0), 1'b0, 16'h0, 1'b0, 1'b0, 1'b0);
			chb(emu_sel, l == 12);
		end
		rreg(R_STATUS, v);
		chb(v[8], 1'b1);
		wreg(R_SEG0 + 6'h4, 32'h0);
		// Execution breakpoint: data read and other fetch must not fire
		a = 24'($urandom);
		wreg(R_BP0, {8'h0, a});
		wreg(R_BP0 + 6'h4, 32'h1);
		cpu.cyc(a, 1'b0, 16'h0, 1'b0, 1'b0, 1'b0);
		chb(halt, 1'b0);
		cpu.cyc(a ^ 24'h2, 1'b0, 16'h0, 1'b1, 1'b0, 1'b0);
		chb(halt, 1'b0);
		cpu.cyc(a, 1'b0, 16'h0, 1'b1, 1'b0, 1'b0);
		chb(halt, 1'b1);
		rreg(R_STATUS, v);
		chk({28'h0, v[3:0]}, 32'h9);
		wreg(R_STATUS, 32'hf);
		// Halt request trails the cleared flag by one clock
		@(posedge clk);
		#1 chb(halt, 1'b0);
		rreg(R_STATUS, v);
		chk({28'h0, v[3:0]}, 32'h0);
		wreg(R_BP0 + 6'h4, 32'h9);
		cpu.cyc(a, 1'b0, 16'h0, 1'b1, 1'b0, 1'b0);
		chb(halt, 1'b0);
		rreg(R_STATUS, v);
		chb(v[0], 1'b1);
		wreg(R_BP0 + 6'h4, 32'h0);
		// Range without halting, seen on the general trigger
		lo = 24'($urandom) & 24'h7fff00;
		wreg(R_RANGE_LO, {8'h0, lo});
		wreg(R_RANGE_HI, {8'h0, lo + 24'h10});
		wreg(R_RANGE_CTL, 32'h3);
		wreg(R_SEL, 32'h60);
		for (int k = 0; k < 4; k++) begin
			d = k[1] * 17 + k[0] - 1;
			cpu.cyc(lo + 24'(d), k[0], 16'h0, 1'b0, 1'b0, 1'b0);
			chb(gtrig, k[0] ^ k[1]);
		end
		chb(halt, 1'b0);
		// Expression: (sync0 and not sync1) or range
		wreg(R_SEL, 32'h200);
		wreg(R_TERM0, 32'h02000300);
		wreg(R_TERM0 + 6'h1, 32'h8);
		for (int k = 0; k < 5; k++) begin
			cpu.cyc(k == 4 ? lo : ~lo, 1'b0, 16'h0, 1'b0, k[0], k[1]);
			chb(gtrig, k == 1 || k == 4);
		end
		wreg(R_RANGE_CTL, 32'h0);
		// Count three bus cycles
		wreg(R_CNT_CFG, 32'h20003);
		for (int k = 0; k < 3; k++) begin
			cpu.cyc(~lo, 1'b0, 16'h0, 1'b0, 1'b0, 1'b0);
			rreg(R_STATUS, v);
			chb(v[5], k == 2);
		end
		// Stop on sync0 through the stop selector, then clear it
		wreg(R_SEL, 32'h100008);
		cpu.cyc(~lo, 1'b0, 16'h0, 1'b0, 1'b1, 1'b0);
		chb(halt, 1'b1);
		wreg(R_STATUS, 32'h8);
		@(posedge clk);
		#1 chb(halt, 1'b0);
		// Bus trace ended by sync1 on the second cycle, two further entries
		td = 16'($urandom);
		wreg(R_SEL, 32'h48000);
		wreg(R_TDELAY, 32'h2);
		wreg(R_CTRL, 32'h3);
		n_trc = 0;
		for (int k = 0; k < 5; k++)
			cpu.cyc(~lo + 24'(k), 1'b1, td ^ 16'(k), 1'b0, 1'b0, k == 1);
		chk(n_trc, 32'h4);
		rreg(R_STATUS, v);
		chb(v[6], 1'b1);
		chk({24'h0, v[23:16]}, 32'h4);
		wreg(R_TIDX, 32'h1);
		rreg(R_TDATA_LO, v);
		chk(v, {td[7:0] ^ 8'h1, ~lo + 24'h1});
		summarize();
	end
endmodule
